// file: hdl/prt_top.sv
// Four reload timers with latched count readout, toggle outputs and interrupts.
// Assumes rtc_clk_in is asynchronous and bus strobes are single-cycle, synchronous.
//
// Design decision made here: the plain strobed port.
`timescale 1ns/100ps
module prt_top #(
   parameter int NUM_TMR = prt_pkg::NUM_TMR
) (
   input  wire logic          clk_sys,
   input  wire logic          rst_b,
   input  wire prt_pkg::prt_bus_t bus,
   input  wire logic          rtc_clk_in,
   output logic [7:0]         rdata,
   output logic               toggle_out_pin0,
   output logic               toggle_out_pin0_oe,
   output logic               toggle_out_pin2,
   output logic               toggle_out_pin2_oe,
   output logic               irq,
   output logic               timer_irq_n
);
   logic [2:0]         rtc_sync_q;
   logic               rtc_tick;
   logic [7:0]         ctl_q   [NUM_TMR];
   logic [15:0]        reload_q[NUM_TMR];
   logic [15:0]        count_q [NUM_TMR];
   logic [7:0]         hold_q  [NUM_TMR];
   logic [NUM_TMR-1:0] ident_q;
   logic [NUM_TMR-1:0] toggle_out_pin_q;
   logic [NUM_TMR-1:0] eoc;
   logic [NUM_TMR-1:0] stat_q;
   logic [NUM_TMR-1:0] en_q;
   logic [7:0]         pin_cfg_q;
   logic [7:0]         rdata_d;

   // Two flops before the edge detector; the first flop is read by nothing else.
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         rtc_sync_q <= 3'h0;
      end else begin
         rtc_sync_q <= {rtc_sync_q[1:0], rtc_clk_in};
      end
   end
   assign rtc_tick = rtc_sync_q[1] & ~rtc_sync_q[2];

   genvar g;
   generate
      for (g = 0; g < NUM_TMR; g++) begin : g_tmr
         logic tick;
         logic hit_lo, hit_hi, hit_ctl, hit_rld, hit_id;
         assign hit_lo  = bus.addr == prt_pkg::ADDR_LO[g];
         assign hit_hi  = bus.addr == prt_pkg::ADDR_HI[g];
         assign hit_ctl = bus.addr == prt_pkg::ADDR_CTL[g];
         assign hit_rld = bus.addr == prt_pkg::ADDR_RLD_LO[g];
         assign hit_id  = bus.addr == prt_pkg::ADDR_IDENT[g];
         assign tick = ctl_q[g][prt_pkg::CTL_CLKSEL] ? rtc_tick : 1'b1;
         assign eoc[g] = ctl_q[g][prt_pkg::CTL_EN] & tick & (count_q[g] == prt_pkg::ONE_WORD);

         always_ff @(posedge clk_sys or negedge rst_b) begin
            if (!rst_b) begin
               ctl_q[g] <= prt_pkg::RST_BYTE;
            end else if (bus.wr && hit_ctl) begin
               ctl_q[g] <= bus.wdata;
            end else if (eoc[g] && !ctl_q[g][prt_pkg::CTL_CONT]) begin
               ctl_q[g][prt_pkg::CTL_EN] <= 1'b0;
            end
         end

         // Reload high shares the count-high address: writes land here, reads see the count.
         always_ff @(posedge clk_sys or negedge rst_b) begin
            if (!rst_b) begin
               reload_q[g] <= prt_pkg::RST_WORD;
            end else if (bus.wr && hit_rld) begin
               reload_q[g][7:0] <= bus.wdata;
            end else if (bus.wr && hit_hi) begin
               reload_q[g][15:8] <= bus.wdata;
            end
         end

         // Count reads touch only the holding byte, so counting never stalls.
         always_ff @(posedge clk_sys or negedge rst_b) begin
            if (!rst_b) begin
               count_q[g] <= prt_pkg::RST_WORD;
            end else if (bus.wr && hit_ctl && bus.wdata[prt_pkg::CTL_EN]) begin
               count_q[g] <= reload_q[g];
            end else if (ctl_q[g][prt_pkg::CTL_EN] && tick) begin
               count_q[g] <= eoc[g] ? reload_q[g] : count_q[g] - prt_pkg::ONE_WORD;
            end
         end

         always_ff @(posedge clk_sys or negedge rst_b) begin
            if (!rst_b) begin
               hold_q[g] <= prt_pkg::RST_BYTE;
            end else if (bus.rd && hit_lo) begin
               hold_q[g] <= count_q[g][15:8];
            end
         end

         always_ff @(posedge clk_sys or negedge rst_b) begin
            if (!rst_b) begin
               toggle_out_pin_q[g] <= 1'b0;
            end else if (eoc[g]) begin
               toggle_out_pin_q[g] <= ~toggle_out_pin_q[g];
            end
         end

         // A new end of count with CTL_IE set wins over the clearing read.
         always_ff @(posedge clk_sys or negedge rst_b) begin
            if (!rst_b) begin
               ident_q[g] <= 1'b0;
            end else if (eoc[g] && ctl_q[g][prt_pkg::CTL_IE]) begin
               ident_q[g] <= 1'b1;
            end else if (bus.rd && hit_id) begin
               ident_q[g] <= 1'b0;
            end
         end

         always_ff @(posedge clk_sys or negedge rst_b) begin
            if (!rst_b) begin
               stat_q[g] <= 1'b0;
            end else if (eoc[g]) begin
               stat_q[g] <= 1'b1;
            end else if (bus.wr && bus.addr == prt_pkg::ADDR_IRQ_CLR && bus.wdata[g]) begin
               stat_q[g] <= 1'b0;
            end
         end
      end
   endgenerate

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         pin_cfg_q <= prt_pkg::RST_BYTE;
         en_q      <= '0;
      end else if (bus.wr && bus.addr == prt_pkg::ADDR_PIN_CFG) begin
         pin_cfg_q <= bus.wdata;
      end else if (bus.wr && bus.addr == prt_pkg::ADDR_IRQ_EN) begin
         en_q <= bus.wdata[NUM_TMR-1:0];
      end
   end

   always_comb begin
      rdata_d = prt_pkg::RST_BYTE;
      for (int i = 0; i < NUM_TMR; i++) begin
         if (bus.addr == prt_pkg::ADDR_LO[i]) rdata_d = count_q[i][7:0];
         if (bus.addr == prt_pkg::ADDR_HI[i]) rdata_d = hold_q[i];
         if (bus.addr == prt_pkg::ADDR_CTL[i]) rdata_d = ctl_q[i];
         if (bus.addr == prt_pkg::ADDR_RLD_LO[i]) rdata_d = reload_q[i][7:0];
         if (bus.addr == prt_pkg::ADDR_IDENT[i]) rdata_d = {7'h00, ident_q[i]};
      end
      if (bus.addr == prt_pkg::ADDR_PIN_CFG) rdata_d = pin_cfg_q;
      if (bus.addr == prt_pkg::ADDR_IRQ_STAT) rdata_d = {4'h0, stat_q};
      if (bus.addr == prt_pkg::ADDR_IRQ_EN) rdata_d = {4'h0, en_q};
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         rdata <= prt_pkg::RST_BYTE;
      end else if (bus.rd) begin
         rdata <= rdata_d;
      end else begin
         rdata <= prt_pkg::RST_BYTE;
      end
   end

   // Timer 3 toggle logic runs but owns no pin; its pad belongs to the PWM complement.
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         toggle_out_pin0    <= 1'b0;
         toggle_out_pin0_oe <= 1'b0;
         toggle_out_pin2    <= 1'b0;
         toggle_out_pin2_oe <= 1'b0;
         irq                <= 1'b0;
         timer_irq_n        <= 1'b1;
      end else begin
         toggle_out_pin0    <= toggle_out_pin_q[0];
         toggle_out_pin0_oe <= pin_cfg_q[prt_pkg::PIN_OUT0] & pin_cfg_q[prt_pkg::PIN_ALT0];
         toggle_out_pin2    <= toggle_out_pin_q[2];
         toggle_out_pin2_oe <= pin_cfg_q[prt_pkg::PIN_OUT2] & pin_cfg_q[prt_pkg::PIN_ALT2]
                               & ~pin_cfg_q[prt_pkg::PIN_PWM3];
         irq                <= |(stat_q & en_q);
         timer_irq_n        <= ~|ident_q;
      end
   end

   toggle_out_pin_start_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      $rose(rst_b) |-> toggle_out_pin_q == '0) else $error("toggle not zero after reset");
   toggle_out_pin_flip_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      eoc[0] |=> toggle_out_pin_q[0] != $past(toggle_out_pin_q[0])) else $error("toggle missed");
   toggle_out_pin_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      !eoc[1] |=> toggle_out_pin_q[1] == $past(toggle_out_pin_q[1])) else $error("toggle spurious");
   ident_clr_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      bus.rd && bus.addr == prt_pkg::ADDR_IDENT[0] && !eoc[0] |=> !ident_q[0])
      else $error("ident not cleared");
   hold_cap_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      bus.rd && bus.addr == prt_pkg::ADDR_LO[1] |=> hold_q[1] == $past(count_q[1][15:8]))
      else $error("high byte not latched");
   hi_read_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      bus.rd && bus.addr == prt_pkg::ADDR_HI[0] |=> rdata == $past(hold_q[0]))
      else $error("high read wrong");
   lo_read_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      bus.rd && bus.addr == prt_pkg::ADDR_LO[2] |=> rdata == $past(count_q[2][7:0]))
      else $error("low read wrong");
   run_free_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      ctl_q[0][prt_pkg::CTL_EN] && !ctl_q[0][prt_pkg::CTL_CLKSEL] && count_q[0] > prt_pkg::ONE_WORD
      && !bus.wr |=> count_q[0] == $past(count_q[0]) - prt_pkg::ONE_WORD)
      else $error("count disturbed");
   pwm_pin_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      pin_cfg_q[prt_pkg::PIN_PWM3] |=> !toggle_out_pin2_oe) else $error("pin not yielded");
   pin_cfg_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      !pin_cfg_q[prt_pkg::PIN_ALT0] |=> !toggle_out_pin0_oe) else $error("pin driven");
   rtc_sel_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      ctl_q[2][prt_pkg::CTL_CLKSEL] && !rtc_tick && !bus.wr |=> count_q[2] == $past(count_q[2]))
      else $error("rtc select ignored");
   rd_idle_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      !bus.rd |=> rdata == prt_pkg::RST_BYTE) else $error("read data outside slot");
   irq_level_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      1'b1 |=> irq == |($past(stat_q) & $past(en_q))) else $error("irq level wrong");
   eoc_c: cover property (@(posedge clk_sys) disable iff (!rst_b) eoc[0] ##[1:40] eoc[0]);
   read_pair_c: cover property (@(posedge clk_sys) disable iff (!rst_b)
      bus.rd && bus.addr == prt_pkg::ADDR_LO[0] ##1 bus.rd && bus.addr == prt_pkg::ADDR_HI[0]);
   irq_c: cover property (@(posedge clk_sys) disable iff (!rst_b) $rose(irq));
endmodule : prt_top

// file: common/prt_pkg.sv
// Package for the four-channel programmable reload timer block.
// Assumes a single 20 MHz system clock and a byte-wide register port.
package prt_pkg;
   localparam int          NUM_TMR   = 4;
   localparam int          ADDR_W    = 8;
   localparam logic [7:0]  RST_BYTE  = 8'h00;
   localparam logic [15:0] RST_WORD  = 16'h0000;
   localparam logic [15:0] ONE_WORD  = 16'h0001;
   localparam logic [7:0]  ADDR_LO [NUM_TMR] = '{8'h63, 8'h68, 8'h72, 8'h77};
   localparam logic [7:0]  ADDR_HI [NUM_TMR] = '{8'h64, 8'h69, 8'h73, 8'h78};
   localparam logic [7:0]  ADDR_CTL [NUM_TMR] = '{8'h60, 8'h65, 8'h6f, 8'h74};
   localparam logic [7:0]  ADDR_RLD_LO [NUM_TMR] = '{8'h61, 8'h66, 8'h70, 8'h75};
   localparam logic [7:0]  ADDR_IDENT [NUM_TMR] = '{8'h62, 8'h67, 8'h71, 8'h76};
   localparam logic [7:0]  ADDR_PIN_CFG  = 8'h7a;
   localparam logic [7:0]  ADDR_IRQ_STAT = 8'h7b;
   localparam logic [7:0]  ADDR_IRQ_EN   = 8'h7c;
   localparam logic [7:0]  ADDR_IRQ_CLR  = 8'h7d;
   // Control register fields.
   localparam int CTL_EN     = 0;
   localparam int CTL_CONT   = 1;
   localparam int CTL_CLKSEL = 2;
   localparam int CTL_IE     = 3;
   // Pin configuration fields.
   localparam int PIN_OUT0   = 0;
   localparam int PIN_ALT0   = 1;
   localparam int PIN_OUT2   = 2;
   localparam int PIN_ALT2   = 3;
   localparam int PIN_PWM3   = 4;
   localparam int IDENT_EOC  = 0;
   localparam int RTC_SYNC_STAGES = 2;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [7:0]        wdata;
      logic              wr;
      logic              rd;
   } prt_bus_t;
endpackage : prt_pkg

// file: tb/tb_prt_top.sv
// Self-checking bench for the four-channel reload timer block.
// Assumes the block is reached only through its ports, with the bench as bus master.
`timescale 1ns/100ps
module tb_prt_top;
   logic              clk_sys    = 1'b0;
   logic              rst_b      = 1'b0;
   logic              rtc_clk_in = 1'b0;
   prt_pkg::prt_bus_t bus        = '0;
   logic [7:0]        rdata;
   logic [7:0]        v;
   logic              p0;
   logic              p0_oe;
   logic              p2;
   logic              p2_oe;
   logic              irq;
   logic              tirq_n;
   logic [31:0]       seed       = 32'h48fd;
   int                miscompares = 0;
   int                cmp_count   = 0;
   int                n;
   int                r;
   int                k;
   localparam logic [7:0] CFG [6] = '{8'h00, 8'h01, 8'h02, 8'h0c, 8'h1c, 8'h03};
   localparam logic [1:0] OEX [6] = '{2'h0, 2'h0, 2'h0, 2'h2, 2'h0, 2'h1};

   always #25 clk_sys = ~clk_sys;

   prt_top prt_top_i (.clk_sys(clk_sys), .rst_b(rst_b), .bus(bus), .rtc_clk_in(rtc_clk_in), .rdata(rdata),
      .toggle_out_pin0(p0), .toggle_out_pin0_oe(p0_oe), .toggle_out_pin2(p2), .toggle_out_pin2_oe(p2_oe),
      .irq(irq), .timer_irq_n(tirq_n));

   function logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : xs

   task print_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : print_verdict

   task chk(input logic [15:0] g, input logic [15:0] e);
      cmp_count++;
      if (g !== e) begin
         miscompares++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk

   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      bus <= '{a, d, 1'b1, 1'b0};
      @(posedge clk_sys);
      bus <= '0;
   endtask : wr

   // Read data stand only in the cycle after the strobe, so they are sampled there.
   task rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_sys);
      bus <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge clk_sys);
      bus <= '0;
      #1 d = rdata;
   endtask : rd

   // Counts clock edges until the pin changes; a bounded wait so a dead timer cannot hang the run.
   task wait_chg(output int c);
      logic o;
      #1 o = p0;
      c = 0;
      while (p0 === o && c < 2000) begin
         @(posedge clk_sys);
         #1 c++;
      end
      if (c >= 2000) begin
         miscompares++;
         print_verdict();
      end
   endtask : wait_chg

   initial begin
      repeat (2) @(posedge clk_sys);
      rst_b <= 1'b1;
      #1 chk(tirq_n, 1'b1);
      chk({irq, p0, p0_oe, p2, p2_oe}, 0);
      for (int i = 0; i < 4; i++) begin
         rd(prt_pkg::ADDR_HI[i], v);
         chk(v, 8'h00);
         rd(prt_pkg::ADDR_LO[i], v);
         chk(v, 8'h00);
      end
      wr(8'hf0, 8'(xs() >> 8));
      rd(8'hf0, v);
      chk(v, 8'h00);
      for (int i = 0; i < 6; i++) begin
         wr(8'h7a, CFG[i]);
         repeat (2) @(posedge clk_sys);
         #1 chk({p2_oe, p0_oe}, OEX[i]);
      end
      chk(p0, 1'b0);
      r = 4 + (xs() % 8);
      wr(8'h61, r[7:0]);
      wr(8'h64, 8'h00);
      wr(8'h60, 8'h03);
      wait_chg(n);
      chk(p0, 1'b1);
      wait_chg(n);
      chk(n, r);
      fork
         wait_chg(n);
         begin
            rd(8'h63, v);
            rd(8'h64, v);
         end
      join
      chk(n, r);
      wr(8'h70, 8'h10);
      wr(8'h73, 8'h00);
      wr(8'h6f, 8'h05);
      repeat (20) @(posedge clk_sys);
      rd(8'h72, v);
      chk(v, 8'h10);
      k = 1 + (xs() % 4);
      repeat (k) begin
         repeat (4) @(posedge clk_sys) rtc_clk_in <= 1'b1;
         repeat (4) @(posedge clk_sys) rtc_clk_in <= 1'b0;
      end
      repeat (6) @(posedge clk_sys);
      rd(8'h72, v);
      chk(v, 8'h10 - k);
      wr(8'h75, 8'h00);
      wr(8'h78, 8'h03);
      wr(8'h74, 8'h03);
      rd(8'h77, v);
      chk(v > 8'he0, 1'b1);
      repeat (300) @(posedge clk_sys);
      rd(8'h78, v);
      chk(v, 8'h02);
      wr(8'h60, 8'h00);
      wr(8'h74, 8'h00);
      wr(8'h7d, 8'hff);
      wr(8'h66, 8'h05);
      wr(8'h69, 8'h00);
      wr(8'h65, 8'h09);
      n = 0;
      while (tirq_n !== 1'b0 && n < 100) begin
         @(posedge clk_sys);
         #1 n++;
      end
      if (n >= 100) begin
         miscompares++;
         print_verdict();
      end
      rd(8'h7b, v);
      chk(v, 8'h02);
      wr(8'h7c, 8'h02);
      repeat (2) @(posedge clk_sys);
      #1 chk(irq, 1'b1);
      wr(8'h7c, 8'h00);
      repeat (2) @(posedge clk_sys);
      #1 chk(irq, 1'b0);
      wr(8'h7c, 8'h02);
      wr(8'h7d, 8'h02);
      repeat (2) @(posedge clk_sys);
      #1 chk(irq, 1'b0);
      rd(8'h67, v);
      chk(v, 8'h01);
      repeat (2) @(posedge clk_sys);
      #1 chk(tirq_n, 1'b1);
      rd(8'h67, v);
      chk(v, 8'h00);
      print_verdict();
   end
endmodule : tb_prt_top
